// *** rtl/vsng_node.sv ***
// Virtual scan node glue: instruction decode, data chains, bypass, core handoff
// Summary of operation
// - Updated virtual instruction shown on parallel output after update-instruction state.
// - Instruction decode picks exactly one user data chain or bypass as scan path.
// - One-hot virtual states decide chain shift and chain update moments.
// - Core exchanges parallel data with chains only outside shift states.
// - Outgoing value loaded into selected chain during capture-data state.
// - Selected chain shifts one bit toward output only in shift-data state.
// - Core takes scanned-in value only after update-data state.
// - Every instruction code selects some chain; serial path never breaks.
// - Unmapped instruction codes select the bypass register.
// - All scan logic clocked by core clock on sampled test clock edges; test clock at most 10 MHz.
// - Crossings into core clock use proper synchronisation.
// - Core may parallel load the virtual instruction for capture.
// - Instruction field width uniform, at least four bits.
`timescale 1ns/10ps
`default_nettype none
`include "vsng_regs.svh"
module vsng_node
  import vsng_pkg::*;
(
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_b_in,
  input  wire logic                        tck_in,
  input  wire logic                        tdi_in,
  input  wire logic                        vstate_cdr_in,
  input  wire logic                        vstate_sdr_in,
  input  wire logic                        vstate_udr_in,
  input  wire logic                        vstate_cir_in,
  input  wire logic                        vstate_uir_in,
  input  wire logic                        vir_tdi_in,
  input  wire logic                        vir_shift_in,
  input  wire logic [`VSNG_IR_WIDTH-1:0]   instr_parallel_load_in,
  input  wire logic [`VSNG_DR_WIDTH-1:0]   chain_a_load_in,
  input  wire logic [`VSNG_DR_WIDTH-1:0]   chain_b_load_in,
  output logic                             tdo_out,
  output logic                             vir_tdo_out,
  output logic [`VSNG_IR_WIDTH-1:0]        instr_out,
  output logic [`VSNG_DR_WIDTH-1:0]        chain_a_data_out,
  output logic [`VSNG_DR_WIDTH-1:0]        chain_b_data_out,
  output logic                             chain_a_valid_out,
  output logic                             chain_b_valid_out
);

  // All nine test-side pins pass two flops before use; tck edges found in core clock
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic             tck_prev;
  logic [NSYNC-1:0] raw_pins;
  logic [NSYNC-1:0] next_sync1;
  logic [NSYNC-1:0] next_sync2;
  logic             next_tck_prev;

  assign raw_pins = {tck_in, tdi_in, vstate_cdr_in, vstate_sdr_in, vstate_udr_in,
                     vstate_cir_in, vstate_uir_in, vir_tdi_in, vir_shift_in};

  // Only the second stage is read, so a metastable first stage never leaks
  always_comb
  begin
    next_sync1    = raw_pins;
    next_sync2    = sync1;
    next_tck_prev = sync2[NSYNC-1];
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sync1    <= '0;
      sync2    <= '0;
      tck_prev <= 1'b0;
    end
    else
    begin
      sync1    <= next_sync1;
      sync2    <= next_sync2;
      tck_prev <= next_tck_prev;
    end
  end

  logic s_tck;
  logic s_tdi;
  logic s_cdr;
  logic s_sdr;
  logic s_udr;
  logic s_cir;
  logic s_uir;
  logic s_vir_tdi;
  logic s_vir_shift;
  logic tck_rise;
  logic tck_fall;

  assign {s_tck, s_tdi, s_cdr, s_sdr, s_udr, s_cir, s_uir, s_vir_tdi, s_vir_shift} = sync2;
  // Test clock edges drive all scan state; slow tck keeps this exact
  assign tck_rise = s_tck & ~tck_prev;
  assign tck_fall = ~s_tck & tck_prev;

  function automatic vsng_sel_t decode_instr(input logic [`VSNG_IR_WIDTH-1:0] code);
    case (code)
      `VSNG_CODE_CHAIN_A: decode_instr = VSNG_SEL_CHAIN_A;
      `VSNG_CODE_CHAIN_B: decode_instr = VSNG_SEL_CHAIN_B;
      default:            decode_instr = VSNG_SEL_BYPASS;
    endcase
  endfunction : decode_instr

  // Chains move toward the serial output, LSB first, fresh bit at the MSB
  function automatic logic [`VSNG_DR_WIDTH-1:0] shift_chain(
    input logic                      bit_in,
    input logic [`VSNG_DR_WIDTH-1:0] chain
  );
    return {bit_in, chain[`VSNG_DR_WIDTH-1:1]};
  endfunction : shift_chain

  function automatic logic chain_lsb(
    input vsng_sel_t                 s,
    input logic [`VSNG_DR_WIDTH-1:0] a,
    input logic [`VSNG_DR_WIDTH-1:0] b,
    input logic                      byp
  );
    case (s)
      VSNG_SEL_CHAIN_A: chain_lsb = a[0];
      VSNG_SEL_CHAIN_B: chain_lsb = b[0];
      default:          chain_lsb = byp;
    endcase
  endfunction : chain_lsb

  // Virtual instruction shift and hold registers
  logic [`VSNG_IR_WIDTH-1:0] ir_shift;
  logic [`VSNG_IR_WIDTH-1:0] ir_hold;
  logic [`VSNG_IR_WIDTH-1:0] next_ir_shift;
  logic [`VSNG_IR_WIDTH-1:0] next_ir_hold;

  always_comb
  begin
    next_ir_shift = ir_shift;
    if (tck_rise && s_cir)
      next_ir_shift = instr_parallel_load_in;
    else if (tck_rise && s_vir_shift)
      next_ir_shift = {s_vir_tdi, ir_shift[`VSNG_IR_WIDTH-1:1]};
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ir_shift <= `VSNG_IR_RESET;
    end
    else
    begin
      ir_shift <= next_ir_shift;
    end
  end

  // Update on falling test clock, as the hub does, after the last shift settled
  always_comb
  begin
    next_ir_hold = ir_hold;
    if (tck_fall && s_uir)
      next_ir_hold = ir_shift;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ir_hold <= `VSNG_IR_RESET;
    end
    else
    begin
      ir_hold <= next_ir_hold;
    end
  end

  vsng_sel_t sel;
  assign sel = decode_instr(ir_hold);
  // Serial output follows the new selection in the same cycle as instr_out
  vsng_sel_t next_sel;
  assign next_sel = decode_instr(next_ir_hold);

  // Data chains and bypass
  logic [`VSNG_DR_WIDTH-1:0] chain_a;
  logic [`VSNG_DR_WIDTH-1:0] chain_b;
  logic                      bypass;
  logic [`VSNG_DR_WIDTH-1:0] next_chain_a;
  logic [`VSNG_DR_WIDTH-1:0] next_chain_b;
  logic                      next_bypass;

  always_comb
  begin
    next_chain_a = chain_a;
    next_chain_b = chain_b;
    next_bypass  = bypass;
    if (tck_rise && s_cdr)
    begin
      // Core value sampled only at capture, never while shifting
      case (sel)
        VSNG_SEL_CHAIN_A: next_chain_a = chain_a_load_in;
        VSNG_SEL_CHAIN_B: next_chain_b = chain_b_load_in;
        default:          next_bypass  = 1'b0;
      endcase
    end
    else if (tck_rise && s_sdr)
    begin
      case (sel)
        VSNG_SEL_CHAIN_A: next_chain_a = shift_chain(s_tdi, chain_a);
        VSNG_SEL_CHAIN_B: next_chain_b = shift_chain(s_tdi, chain_b);
        default:          next_bypass  = s_tdi;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      chain_a <= `VSNG_DR_RESET;
      chain_b <= `VSNG_DR_RESET;
      bypass  <= 1'b0;
    end
    else
    begin
      chain_a <= next_chain_a;
      chain_b <= next_chain_b;
      bypass  <= next_bypass;
    end
  end

  // Parallel handoff to core after update-data
  logic [`VSNG_DR_WIDTH-1:0] next_a_data;
  logic [`VSNG_DR_WIDTH-1:0] next_b_data;
  logic                      next_a_valid;
  logic                      next_b_valid;
  logic                      next_tdo;
  logic                      next_vir_tdo;

  always_comb
  begin
    next_a_data  = chain_a_data_out;
    next_b_data  = chain_b_data_out;
    next_a_valid = 1'b0;
    next_b_valid = 1'b0;
    if (tck_fall && s_udr)
    begin
      if (sel == VSNG_SEL_CHAIN_A)
      begin
        next_a_data  = chain_a;
        next_a_valid = 1'b1;
      end
      if (sel == VSNG_SEL_CHAIN_B)
      begin
        next_b_data  = chain_b;
        next_b_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      chain_a_data_out  <= `VSNG_DR_RESET;
      chain_b_data_out  <= `VSNG_DR_RESET;
      chain_a_valid_out <= 1'b0;
      chain_b_valid_out <= 1'b0;
    end
    else
    begin
      chain_a_data_out  <= next_a_data;
      chain_b_data_out  <= next_b_data;
      chain_a_valid_out <= next_a_valid;
      chain_b_valid_out <= next_b_valid;
    end
  end

  // Serial outputs come from next values so they leave with the chain update
  always_comb
  begin
    next_tdo     = chain_lsb(next_sel, next_chain_a, next_chain_b, next_bypass);
    next_vir_tdo = next_ir_shift[0];
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tdo_out     <= 1'b0;
      vir_tdo_out <= 1'b0;
    end
    else
    begin
      tdo_out     <= next_tdo;
      vir_tdo_out <= next_vir_tdo;
    end
  end

  assign instr_out = ir_hold;

endmodule : vsng_node
`default_nettype wire

// *** rtl/vsng_regs.svh ***
// Constants for the virtual scan node glue
`ifndef VSNG_REGS_SVH
`define VSNG_REGS_SVH
`define VSNG_IR_WIDTH        4
`define VSNG_DR_WIDTH        8
`define VSNG_CODE_CHAIN_A    4'h1
`define VSNG_CODE_CHAIN_B    4'h2
`define VSNG_IR_RESET        4'h0
`define VSNG_DR_RESET        8'h00
`define VSNG_SELECT_VINSTR   10'h00E
`define VSNG_SELECT_VDATA    10'h00C
`define VSNG_PHYS_IR_WIDTH   10
`define VSNG_TCK_MAX_MHZ     10
`endif

// *** rtl/vsng_pkg.sv ***
// Types for the virtual scan node glue
package vsng_pkg;
  typedef enum logic [1:0] {
    VSNG_SEL_BYPASS,
    VSNG_SEL_CHAIN_A,
    VSNG_SEL_CHAIN_B
  } vsng_sel_t;
endpackage : vsng_pkg

// *** test/vsng_checker.sv ***
// Assertion checker for the scan node glue
`timescale 1ns/10ps
`default_nettype none
`include "vsng_regs.svh"
module vsng_checker (
  input wire logic       core_clk_in,
  input wire logic       rst_b_in,
  input wire logic       tck_in,
  input wire logic       tdi_in,
  input wire logic       vstate_cdr_in,
  input wire logic       vstate_sdr_in,
  input wire logic       vstate_udr_in,
  input wire logic       vstate_cir_in,
  input wire logic       vstate_uir_in,
  input wire logic [3:0] instr_parallel_load_in,
  input wire logic [7:0] chain_a_load_in,
  input wire logic       tdo_out,
  input wire logic       vir_tdo_out,
  input wire logic [3:0] instr_out,
  input wire logic       chain_a_valid_out,
  input wire logic       chain_b_valid_out
);
  logic [2:0] sy;
  wire logic  ri = sy[1] & ~sy[2];
  wire logic  fa = ~sy[1] & sy[2];
  wire logic  is_a = instr_out == `VSNG_CODE_CHAIN_A;
  wire logic  byp = !is_a && instr_out != `VSNG_CODE_CHAIN_B;
  // Same two-flop depth as the design, so edges line up
  always_ff @(posedge core_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      sy <= 3'h0;
    else
      sy <= {sy[1:0], tck_in};
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence pulse_s(logic v);
    v ##1 !v;
  endsequence
  tdo_timing_a: assert property (
    $changed(tdo_out) |-> $past(ri) || $past(fa)) else $error("tdo off edge");
  instr_update_a: assert property (
    $changed(instr_out) |-> $past(fa) && $past(vstate_uir_in)) else $error("instr early");
  a_update_a: assert property (
    fa && vstate_udr_in && is_a |=> pulse_s(chain_a_valid_out)) else $error("no A pulse");
  b_update_a: assert property (
    fa && vstate_udr_in && instr_out == `VSNG_CODE_CHAIN_B |=> pulse_s(chain_b_valid_out))
    else $error("no B pulse");
  a_cause_a: assert property (
    chain_a_valid_out |-> $past(fa) && $past(vstate_udr_in) && $past(is_a)) else $error("A");
  b_cause_a: assert property (
    chain_b_valid_out |-> $past(vstate_udr_in) && $past(instr_out) == `VSNG_CODE_CHAIN_B)
    else $error("B pulse");
  capture_a: assert property (
    ri && vstate_cdr_in && is_a |=> tdo_out == $past(chain_a_load_in[0])) else $error("cap");
  bypass_shift_a: assert property (
    ri && vstate_sdr_in && byp |=> tdo_out == $past(tdi_in)) else $error("bypass");
  vir_load_a: assert property (
    ri && vstate_cir_in |=> vir_tdo_out == $past(instr_parallel_load_in[0])) else $error("vir");
endmodule : vsng_checker
bind vsng_node vsng_checker vsng_checker_i (.core_clk_in, .rst_b_in, .tck_in, .tdi_in,
  .vstate_cdr_in, .vstate_sdr_in, .vstate_udr_in, .vstate_cir_in, .vstate_uir_in,
  .instr_parallel_load_in, .chain_a_load_in, .tdo_out, .vir_tdo_out, .instr_out,
  .chain_a_valid_out, .chain_b_valid_out);
`default_nettype wire

// *** test/vsng_hub_model.sv ***
// Hub and test controller model driving the node pins
`timescale 1ns/10ps
`default_nettype none
`include "vsng_regs.svh"
module vsng_hub_model (
  output logic      tck_out,
  output logic      tdi_out,
  output logic      cdr_out,
  output logic      sdr_out,
  output logic      udr_out,
  output logic      cir_out,
  output logic      uir_out,
  output logic      vsh_out,
  input  wire logic tdo_in,
  input  wire logic vtdo_in
);
  logic [`VSNG_PHYS_IR_WIDTH-1:0] phys_ir;
  initial
    {tck_out, tdi_out, cdr_out, sdr_out, udr_out, cir_out, uir_out, vsh_out} = 8'h00;
  // 125 ns period, under 10 MHz; pins move mid-low only
  // Hub address of node index 0; value arbitrary, the hub consumes it
  localparam logic NODE_ADDR = 1'b1;
  // States stay up past the fall, so update strobes see them; scans clear them
  task automatic tick(input logic [5:0] st, input logic d, output logic q, vq);
    {cdr_out, sdr_out, udr_out, cir_out, uir_out, vsh_out} = st;
    tdi_out = d;
    #31.25 q = tdo_in;
    vq = vtdo_in;
    tck_out = 1'b1;
    #62.5 tck_out = 1'b0;
    #31.25;
  endtask : tick
  task automatic ir_scan(input logic [3:0] v, input logic cap, output logic [3:0] o);
    logic q, vq;
    phys_ir = `VSNG_SELECT_VINSTR;
    o = 4'h0;
    if (cap)
      tick(6'h04, 1'b0, q, vq);
    tick(6'h00, NODE_ADDR, q, vq);
    for (int i = 0; i < `VSNG_IR_WIDTH; i++)
    begin
      tick(6'h01, v[i], q, vq);
      o = {vq, o[3:1]};
    end
    tick(6'h02, 1'b0, q, vq);
    {cdr_out, sdr_out, udr_out, cir_out, uir_out, vsh_out} = 6'h00;
    tdi_out = ~tdi_out;
  endtask : ir_scan
  task automatic dr_scan(input logic [7:0] din, output logic [7:0] dout);
    logic q, vq;
    phys_ir = `VSNG_SELECT_VDATA;
    dout = 8'h00;
    tick(6'h20, 1'b0, q, vq);
    for (int i = 0; i < `VSNG_DR_WIDTH; i++)
    begin
      if (i == 4) // Pause with junk on tdi
        tick(6'h00, ~din[i], q, vq);
      tick(6'h10, din[i], q, vq);
      dout = {q, dout[7:1]};
    end
    tick(6'h08, 1'b0, q, vq);
    {cdr_out, sdr_out, udr_out, cir_out, uir_out, vsh_out} = 6'h00;
    tdi_out = ~tdi_out;
  endtask : dr_scan
endmodule : vsng_hub_model
`default_nettype wire

// *** test/vsng_node_tb.sv ***
// Self-checking bench for the scan node glue
`timescale 1ns/10ps
`default_nettype none
`include "vsng_regs.svh"
module vsng_node_tb;
  logic        core_clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        tck, tdi, cdr, sdr, udr, cir, uir, vsh, tdo, vtdo, va, vb;
  logic [3:0]  pld = 4'h0, code, prev, o, ins;
  logic [7:0]  la = 8'h00, lb = 8'h00, da, db, ea, eb, din, dout;
  logic [31:0] rnd = 32'hFBEF5C7F;
  int          error_cnt = 0;
  int          total_checks = 0;
  always #5 core_clk_in = ~core_clk_in;
  vsng_hub_model vsng_hub_model_i (.tck_out(tck), .tdi_out(tdi), .cdr_out(cdr),
    .sdr_out(sdr), .udr_out(udr), .cir_out(cir), .uir_out(uir), .vsh_out(vsh),
    .tdo_in(tdo), .vtdo_in(vtdo));
  vsng_node vsng_node_i (.core_clk_in, .rst_b_in, .tck_in(tck), .tdi_in(tdi),
    .vstate_cdr_in(cdr), .vstate_sdr_in(sdr), .vstate_udr_in(udr), .vstate_cir_in(cir),
    .vstate_uir_in(uir), .vir_tdi_in(tdi), .vir_shift_in(vsh), .instr_parallel_load_in(pld),
    .chain_a_load_in(la), .chain_b_load_in(lb), .tdo_out(tdo), .vir_tdo_out(vtdo),
    .instr_out(ins), .chain_a_data_out(da), .chain_b_data_out(db),
    .chain_a_valid_out(va), .chain_b_valid_out(vb));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // Bypass reads back zero then tdi one bit late
  function automatic logic [7:0] exp_out(input logic [3:0] c, input logic [7:0] d);
    return c == `VSNG_CODE_CHAIN_A ? la : c == `VSNG_CODE_CHAIN_B ? lb : {d[6:0], 1'b0};
  endfunction : exp_out
  task automatic check(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test;
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  // About 20 frames of 2.3 us each; ample margin
  initial
  begin
    #300000;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    repeat (8) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    check(ins, `VSNG_IR_RESET);
    {prev, ea, eb} = 20'h00000;
    for (int k = 0; k < 20; k++)
    begin
      rnd = xs(rnd);
      code = k < 4 ? 4'(16'hF021 >> (4 * k)) : rnd[3:0];
      @(posedge core_clk_in);
      pld <= rnd[7:4];
      la <= rnd[15:8];
      lb <= rnd[23:16];
      din = rnd[31:24];
      @(posedge core_clk_in);
      vsng_hub_model_i.ir_scan(code, k[0], o);
      repeat (5) @(posedge core_clk_in);
      check(o, k[0] ? pld : prev);
      check(ins, code);
      vsng_hub_model_i.dr_scan(din, dout);
      check(dout, exp_out(code, din));
      ea = code == `VSNG_CODE_CHAIN_A ? din : ea;
      eb = code == `VSNG_CODE_CHAIN_B ? din : eb;
      repeat (5) @(posedge core_clk_in);
      check(da, ea);
      check(db, eb);
      prev = code;
    end
    stop_test();
  end
endmodule : vsng_node_tb
`default_nettype wire
